// >>> pkg/sid_pkg.sv
package sid_pkg;

    // ------------------------------------------------------------
    // Opcodes, first byte of a frame
    // ------------------------------------------------------------
    localparam logic [7:0] READ_UNIQUE_IDENTIFIER_CMD   = 8'h4C;
    localparam logic [7:0] WRITE_SERIAL_NUMBER_CMD      = 8'hC2;
    localparam logic [7:0] READ_SERIAL_NUMBER_CMD       = 8'hC3;
    localparam logic [7:0] DEEP_SLEEP_CMD               = 8'hBA;
    localparam logic [7:0] HIBERNATE_CMD                = 8'hB9;
    localparam logic [7:0] WRITE_ENABLE_LATCH_SET_CMD   = 8'h06;

    // ------------------------------------------------------------
    // Storage layout and values after reset
    // ------------------------------------------------------------
    localparam int         ROW_BYTES       = 8;
    localparam logic [63:0] SERIAL_RESET   = 64'h0;
    // Arbitrary neutral value, stands in for the factory identifier
    localparam logic [63:0] UID_DEFAULT    = 64'h0123_4567_89AB_CDEF;
    localparam logic [2:0]  BIT_LAST       = 3'h7;
    localparam logic [2:0]  BYTE_LAST      = 3'h7;
    localparam logic [2:0]  SYNC_RESET     = 3'h1;

    // ------------------------------------------------------------
    // Timing: figures in ns, counts in core clock cycles
    // ------------------------------------------------------------
    localparam int CORE_CLK_MHZ          = 250;
    localparam int DEEP_SLEEP_ENTRY_NS   = 3000;
    localparam int DEEP_SLEEP_EXIT_NS    = 10000;
    localparam int DEEP_SLEEP_PULSE_NS   = 20;
    localparam int HIBERNATE_ENTRY_NS    = 3000;
    localparam int HIBERNATE_EXIT_NS     = 450000;
    // Longest times round down, least times round up
    localparam int DEEP_SLEEP_ENTRY_CYC  =
        DEEP_SLEEP_ENTRY_NS * CORE_CLK_MHZ / 1000;
    localparam int DEEP_SLEEP_EXIT_CYC   =
        DEEP_SLEEP_EXIT_NS * CORE_CLK_MHZ / 1000;
    localparam int DEEP_SLEEP_PULSE_CYC  =
        (DEEP_SLEEP_PULSE_NS * CORE_CLK_MHZ + 999) / 1000;
    localparam int HIBERNATE_ENTRY_CYC   =
        HIBERNATE_ENTRY_NS * CORE_CLK_MHZ / 1000;
    localparam int HIBERNATE_EXIT_CYC    =
        HIBERNATE_EXIT_NS * CORE_CLK_MHZ / 1000;

    localparam int          TMR_W        = 17;
    localparam logic [16:0] TMR_ZERO     = 17'h0;
    localparam logic [16:0] DS_ENTRY_LD  = 17'(DEEP_SLEEP_ENTRY_CYC - 1);
    localparam logic [16:0] DS_EXIT_LD   = 17'(DEEP_SLEEP_EXIT_CYC - 1);
    localparam logic [16:0] DS_PULSE_LD  = 17'(DEEP_SLEEP_PULSE_CYC - 1);
    localparam logic [16:0] HB_ENTRY_LD  = 17'(HIBERNATE_ENTRY_CYC - 1);

    // ------------------------------------------------------------
    // Power state machine, Gray along the deep sleep path
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        SID_ACTIVE   = 3'h0,
        SID_ENTER_DS = 3'h1,
        SID_DEEP     = 3'h3,
        SID_WAKE_DS  = 3'h2,
        SID_ENTER_HB = 3'h6,
        SID_HIB      = 3'h7,
        SID_WAKE_HB  = 3'h5
    } sid_state_t;

endpackage

// >>> design/sid_cmd.sv
`timescale 1ns/1ps
// Functional notes
// - Identifier opcode shifts out the 8-byte read-only factory identifier.
// - Identifier and serial number go out byte 0 first, byte 7 last.
// - An 8-byte user-programmable serial number store is provided.
// - Serial number reads all zero as shipped.
// - Serial-number read bursts bytes and wraps after the eighth.
// - Deep-sleep opcode then select rise enters deep sleep after delay.
// - Deep sleep ignores clock and data in, SO high impedance.
// - Chip-select low pulse of minimum width wakes deep sleep after delay.
// - Data pins stay high impedance during deep-sleep wake-up.
// - Hibernate opcode then chip select rise enters hibernate after delay.
// - Hibernate ignores inputs, SO high-Z, wakes on chip select fall.
// - SO stays high impedance during hibernate wake-up.
// - Reads select one whole 64-bit row; serial writes commit byte by byte.
module sid_cmd #(
    parameter logic [63:0] FACTORY_UID     = sid_pkg::UID_DEFAULT,
    parameter int          HB_EXIT_CYCLES  = sid_pkg::HIBERNATE_EXIT_CYC
) (
    input  wire logic core_clk,
    input  wire logic sys_rst,
    input  wire logic spi_sck,
    input  wire logic spi_cs_n,
    input  wire logic spi_si,
    output logic      spi_so,
    output logic      spi_so_oe,
    output logic      deep_sleep_active,
    output logic      hibernate_active
);
    localparam logic [16:0] HB_EXIT_LD = 17'(HB_EXIT_CYCLES - 1);
    // ------------------------------------------------------------
    // Link side: serial clock domain
    // ------------------------------------------------------------
    logic        sleep_hold;
    logic        frame_rst;
    logic [2:0]  bit_cnt;
    logic [6:0]  shift_in;
    logic        got_op;
    logic [7:0]  opcode;
    logic [2:0]  byte_idx;
    logic        wr_done;
    logic        wr_ok;
    logic        wel;
    logic        ds_tog;
    logic        hb_tog;
    logic [63:0] serial;
    wire  [7:0]  rx_byte  = {shift_in, spi_si};
    wire         byte_end = (bit_cnt == sid_pkg::BIT_LAST);
    wire         op_end   = byte_end && !got_op;
    // Frame logic is held in reset outside a frame and while asleep,
    // so clock and data edges in a sleep state have no effect
    assign frame_rst = sys_rst | spi_cs_n | sleep_hold;
    // Opcode compare, used by several decoders
    function automatic logic is_op(input logic [7:0] code,
                                   input logic [7:0] want);
        is_op = (code == want);
    endfunction
    wire op_read_unique_identifier_cmd = is_op(opcode, sid_pkg::READ_UNIQUE_IDENTIFIER_CMD);
    wire op_read_serial_number_cmd = is_op(opcode, sid_pkg::READ_SERIAL_NUMBER_CMD);
    wire op_write_serial_number_cmd = is_op(opcode, sid_pkg::WRITE_SERIAL_NUMBER_CMD);
    wire reading = got_op && (op_read_unique_identifier_cmd || op_read_serial_number_cmd);
    wire sn_we   = byte_end && got_op && op_write_serial_number_cmd && wr_ok && !wr_done;
    // Bit and byte counting, sampled on the rising clock edge
    always_ff @(posedge spi_sck or posedge frame_rst)
    begin
        if (frame_rst)
        begin
            bit_cnt  <= 3'h0;
            shift_in <= 7'h00;
            got_op   <= 1'b0;
            opcode   <= 8'h00;
            byte_idx <= 3'h0;
            wr_done  <= 1'b0;
            wr_ok    <= 1'b0;
        end
        else
        begin
            bit_cnt  <= bit_cnt + 3'h1;
            shift_in <= rx_byte[6:0];
            if (op_end)
            begin
                got_op <= 1'b1;
                opcode <= rx_byte;
                wr_ok  <= wel;
            end
            else if (byte_end)
            begin
                byte_idx <= byte_idx + 3'h1;
                if (byte_idx == sid_pkg::BYTE_LAST)
                    wr_done <= 1'b1;
            end
        end
    end
    // Write latch and sleep requests outlive the frame, so they sit on
    // the device reset only; requests cross as toggles
    always_ff @(posedge spi_sck or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            wel    <= 1'b0;
            ds_tog <= 1'b0;
            hb_tog <= 1'b0;
        end
        else if (op_end && !sleep_hold)
        begin
            if (is_op(rx_byte, sid_pkg::WRITE_ENABLE_LATCH_SET_CMD))
                wel <= 1'b1;
            else if (is_op(rx_byte, sid_pkg::WRITE_SERIAL_NUMBER_CMD))
                wel <= 1'b0;
            if (is_op(rx_byte, sid_pkg::DEEP_SLEEP_CMD))
                ds_tog <= ~ds_tog;
            if (is_op(rx_byte, sid_pkg::HIBERNATE_CMD))
                hb_tog <= ~hb_tog;
        end
    end
    // Serial number bytes, each committed as soon as it is complete;
    // no checksum is formed here, the host supplies it as byte 0
    genvar gi;
    generate
        for (gi = 0; gi < sid_pkg::ROW_BYTES; gi++)
        begin : g_sn
            always_ff @(posedge spi_sck or posedge sys_rst)
            begin
                if (sys_rst)
                    serial[8*gi +: 8] <= sid_pkg::SERIAL_RESET[8*gi +: 8];
                else if (sn_we && byte_idx == 3'(gi))
                    serial[8*gi +: 8] <= rx_byte;
            end
        end
    endgenerate
    // Whole 64-bit row selected first, then one byte from it
    wire [63:0] row     = op_read_unique_identifier_cmd ? FACTORY_UID : serial;
    wire [7:0]  tx_byte = row[8*byte_idx +: 8];
    wire        tx_bit  = tx_byte[~bit_cnt];
    // Output launched on the falling edge, ready for the next rise
    always_ff @(negedge spi_sck or posedge frame_rst)
    begin
        if (frame_rst)
        begin
            spi_so    <= 1'b0;
            spi_so_oe <= 1'b0;
        end
        else
        begin
            spi_so    <= tx_bit;
            spi_so_oe <= reading;
        end
    end
    // ------------------------------------------------------------
    // Core side: power state control
    // ------------------------------------------------------------
    logic [2:0]          sync_m;
    logic [2:0]          sync_s;
    logic [2:0]          sync_d;
    logic                ds_pend;
    logic                hb_pend;
    sid_pkg::sid_state_t state;
    sid_pkg::sid_state_t next_state;
    logic [16:0]         tmr;
    logic [16:0]         next_tmr;
    logic                next_hold;
    // Two-stage synchronisers: {hibernate toggle, deep toggle, select}
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            sync_m <= sid_pkg::SYNC_RESET;
            sync_s <= sid_pkg::SYNC_RESET;
            sync_d <= sid_pkg::SYNC_RESET;
        end
        else
        begin
            sync_m <= {hb_tog, ds_tog, spi_cs_n};
            sync_s <= sync_m;
            sync_d <= sync_s;
        end
    end
    wire cs_low  = ~sync_s[0];
    wire cs_rise = sync_s[0] & ~sync_d[0];
    wire cs_fall = ~sync_s[0] & sync_d[0];
    wire ds_evt  = sync_s[1] ^ sync_d[1];
    wire hb_evt  = sync_s[2] ^ sync_d[2];
    wire leaving = (state != sid_pkg::SID_ACTIVE);
    // Pending requests: a new request wins over a clear in one cycle
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ds_pend <= 1'b0;
            hb_pend <= 1'b0;
        end
        else
        begin
            ds_pend <= ds_evt | (ds_pend & ~cs_fall & ~leaving);
            hb_pend <= hb_evt | (hb_pend & ~cs_fall & ~leaving);
        end
    end
    // Next state; one timer serves entry, exit and pulse width
    always_comb
    begin
        next_state = state;
        next_tmr   = tmr;
        case (state)
            sid_pkg::SID_ACTIVE:
                if (cs_rise && ds_pend)
                begin
                    next_state = sid_pkg::SID_ENTER_DS;
                    next_tmr   = sid_pkg::DS_ENTRY_LD;
                end
                else if (cs_rise && hb_pend)
                begin
                    next_state = sid_pkg::SID_ENTER_HB;
                    next_tmr   = sid_pkg::HB_ENTRY_LD;
                end
            sid_pkg::SID_ENTER_DS:
                if (tmr == sid_pkg::TMR_ZERO)
                    next_state = sid_pkg::SID_DEEP;
                else
                    next_tmr = tmr - 17'h1;
            sid_pkg::SID_DEEP:
                if (!cs_low)
                    next_tmr = sid_pkg::TMR_ZERO;
                else if (tmr == sid_pkg::DS_PULSE_LD)
                begin
                    next_state = sid_pkg::SID_WAKE_DS;
                    next_tmr   = sid_pkg::DS_EXIT_LD;
                end
                else
                    next_tmr = tmr + 17'h1;
            sid_pkg::SID_WAKE_DS:
                if (tmr == sid_pkg::TMR_ZERO)
                    next_state = sid_pkg::SID_ACTIVE;
                else
                    next_tmr = tmr - 17'h1;
            sid_pkg::SID_ENTER_HB:
                if (tmr == sid_pkg::TMR_ZERO)
                    next_state = sid_pkg::SID_HIB;
                else
                    next_tmr = tmr - 17'h1;
            sid_pkg::SID_HIB:
                if (cs_fall)
                begin
                    next_state = sid_pkg::SID_WAKE_HB;
                    next_tmr   = HB_EXIT_LD;
                end
            sid_pkg::SID_WAKE_HB:
                if (tmr == sid_pkg::TMR_ZERO)
                    next_state = sid_pkg::SID_ACTIVE;
                else
                    next_tmr = tmr - 17'h1;
            default:
                next_state = sid_pkg::SID_ACTIVE;
        endcase
    end
    // Sleep and wake-up states all hold the link side quiet;
    // the host must wait out the wake time, opcodes there are lost
    assign next_hold = (next_state == sid_pkg::SID_DEEP)
                    || (next_state == sid_pkg::SID_WAKE_DS)
                    || (next_state == sid_pkg::SID_HIB)
                    || (next_state == sid_pkg::SID_WAKE_HB);
    // State, timer and status flops
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state             <= sid_pkg::SID_ACTIVE;
            tmr               <= sid_pkg::TMR_ZERO;
            sleep_hold        <= 1'b0;
            deep_sleep_active <= 1'b0;
            hibernate_active  <= 1'b0;
        end
        else
        begin
            state             <= next_state;
            tmr               <= next_tmr;
            sleep_hold        <= next_hold;
            deep_sleep_active <= (next_state == sid_pkg::SID_DEEP);
            hibernate_active  <= (next_state == sid_pkg::SID_HIB);
        end
    end

    // ------------------------------------------------------------
    // Assertions and cover points
    // ------------------------------------------------------------
    a_uid_first_bit: assert property (
        @(posedge spi_sck) disable iff (frame_rst)
        (got_op && op_read_unique_identifier_cmd && byte_idx == 3'h0 && bit_cnt == 3'h0)
        |-> spi_so_oe && spi_so == FACTORY_UID[7])
        else $error("identifier byte 0 msb not first");
    a_sn_wrap_order: assert property (
        @(posedge spi_sck) disable iff (frame_rst)
        (got_op && op_read_serial_number_cmd && byte_idx == 3'h7 && byte_end)
        |=> byte_idx == 3'h0 && spi_so == serial[7])
        else $error("serial read does not wrap to byte 0");
    a_sn_byte_store: assert property (
        @(posedge spi_sck) disable iff (sys_rst)
        (sn_we && byte_idx == 3'h0) |=> serial[7:0] == $past(rx_byte))
        else $error("serial byte 0 not stored");
    a_sn_reset_zero: assert property (
        @(posedge core_clk) $fell(sys_rst) |-> serial == 64'h0)
        else $error("serial number not zero after reset");
    a_ds_entry_load: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        (state == sid_pkg::SID_ACTIVE && cs_rise && ds_pend)
        |=> state == sid_pkg::SID_ENTER_DS && tmr == sid_pkg::DS_ENTRY_LD)
        else $error("deep sleep entry not started");
    a_so_hiz_sleep: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        sleep_hold && $past(sleep_hold) |-> !spi_so_oe)
        else $error("SO driven while asleep");
    a_ds_wake_pulse: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        (state == sid_pkg::SID_DEEP && !cs_low) ##1 cs_low [*5]
        |=> state == sid_pkg::SID_WAKE_DS)
        else $error("deep sleep wake pulse missed");
    a_hb_entry_load: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        (state == sid_pkg::SID_ACTIVE && cs_rise && hb_pend && !ds_pend)
        |=> state == sid_pkg::SID_ENTER_HB)
        else $error("hibernate entry not started");
    a_hb_wake_fall: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        (state == sid_pkg::SID_HIB && cs_fall)
        |=> state == sid_pkg::SID_WAKE_HB && sleep_hold ##1 !spi_so_oe)
        else $error("hibernate not left on select fall");
    c_uid_read: cover property (
        @(posedge spi_sck) got_op && op_read_unique_identifier_cmd && byte_idx == 3'h7);
    c_deep_cycle: cover property (@(posedge core_clk)
        state == sid_pkg::SID_WAKE_DS ##1 state == sid_pkg::SID_ACTIVE);
    c_hib_cycle: cover property (@(posedge core_clk)
        state == sid_pkg::SID_WAKE_HB ##1 state == sid_pkg::SID_ACTIVE);
endmodule // sid_cmd

// >>> sim/sid_host.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// SPI host model, far side of the serial link
// ----------------------------------------------------------------
module sid_host (
    output logic      spi_sck,
    output logic      spi_cs_n,
    output logic      spi_si,
    input  wire logic spi_so,
    input  wire logic spi_so_oe
);
    // Idle link: clock parked, chip deselected
    initial
    begin
        spi_sck  = 1'b0;
        spi_cs_n = 1'b1;
        spi_si   = 1'b0;
    end

    // One whole frame: opcode, then nb bytes, all MSB first
    // Clock stands still outside frames, 12 ns period inside
    task automatic frame(input bit mode3, input logic [7:0] op,
                         input int nb, input logic [127:0] tx,
                         output logic [127:0] rx, output logic oe_seen);
        logic [7:0] cur;
        rx      = 'x;
        oe_seen = 1'b0;
        spi_sck = mode3;
        // Odd offset keeps select edges off the core clock edges
        #7;
        spi_cs_n = 1'b0;
        #6;
        for (int i = 0; i < (nb + 1) * 8; i++)
        begin
            cur = (i < 8) ? op : tx[8 * (i / 8 - 1) +: 8];
            spi_sck = 1'b0;
            spi_si  = cur[7 - i % 8];
            #6;
            // Undriven SO reads as unknown so it never matches
            if (i >= 8)
                rx[8 * (i / 8 - 1) + 7 - i % 8] =
                    spi_so_oe ? spi_so : 1'bx;
            oe_seen = oe_seen | spi_so_oe;
            spi_sck = 1'b1;
            #6;
        end
        if (!mode3)
            spi_sck = 1'b0;
        #6;
        spi_cs_n = 1'b1;
        // Released data line must not keep its last value
        spi_si = ~spi_si;
        #25;
    endtask
endmodule // sid_host

// >>> sim/testbench.sv
`timescale 1ns/1ps
module testbench;
    // Arbitrary identifier value for the run
    localparam logic [63:0] UID_VAL = 64'h5A3C_96E1_0F7B_2D48;

    logic         core_clk;
    logic         sys_rst;
    logic         spi_sck;
    logic         spi_cs_n;
    logic         spi_si;
    logic         spi_so;
    logic         spi_so_oe;
    logic         deep_sleep_active;
    logic         hibernate_active;
    int           mismatches;
    int           num_checks;
    int           cnt;
    logic [63:0]  sn;
    logic [127:0] rx;
    logic         oe;

    // ------------------------------------------------------------
    // Design, host model and clocks
    // ------------------------------------------------------------
    sid_cmd #(
        .FACTORY_UID    (UID_VAL),
        .HB_EXIT_CYCLES (50)
    ) sid_cmd_i (
        .core_clk          (core_clk),
        .sys_rst           (sys_rst),
        .spi_sck           (spi_sck),
        .spi_cs_n          (spi_cs_n),
        .spi_si            (spi_si),
        .spi_so            (spi_so),
        .spi_so_oe         (spi_so_oe),
        .deep_sleep_active (deep_sleep_active),
        .hibernate_active  (hibernate_active)
    );

    sid_host sid_host_i (
        .spi_sck   (spi_sck),
        .spi_cs_n  (spi_cs_n),
        .spi_si    (spi_si),
        .spi_so    (spi_so),
        .spi_so_oe (spi_so_oe)
    );

    // Core clock, 4 ns
    initial
    begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] crc8(input logic [55:0] d);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 55; i >= 0; i--)
            c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
        return c;
    endfunction

    // Byte k of a burst, wrapping after the eighth
    function automatic logic [7:0] exp_byte(input logic [63:0] v,
                                            input int k);
        return v[8 * (k % 8) +: 8];
    endfunction

    // Entry delay as seen by wait_flag, which starts about six core
    // cycles after select rises; the synchroniser adds a few more
    function automatic logic entry_ok(input int n, input int cyc);
        return (n + 6 >= cyc) && (n + 6 <= cyc + 8);
    endfunction

    function automatic logic [127:0] rnd128();
        return {$urandom, $urandom, $urandom, $urandom};
    endfunction

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Burst read of nb bytes, compared byte by byte
    task automatic read_cmp(input bit m3, input logic [7:0] op,
                            input logic [63:0] v, input int nb);
        logic [127:0] r;
        logic         o;
        sid_host_i.frame(m3, op, nb, rnd128(), r, o);
        for (int k = 0; k < nb; k++)
            check(r[8 * k +: 8], exp_byte(v, k));
    endtask

    // Bounded wait on a sleep flag, counts core cycles
    task automatic wait_flag(input bit hib, output int n);
        n = 0;
        while ((hib ? hibernate_active : deep_sleep_active) !== 1'b1)
        begin
            @(posedge core_clk);
            n++;
            if (n > 2000)
            begin
                mismatches++;
                end_sim();
            end
        end
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        mismatches = 0;
        num_checks = 0;
        sys_rst    = 1'b1;
        void'($urandom(32'h3751FFA5));
        repeat (4) @(posedge core_clk);
        sys_rst <= 1'b0;
        repeat (3) @(posedge core_clk);
        check({6'h0, deep_sleep_active, hibernate_active}, 8'h00);
        read_cmp(1'b0, sid_pkg::READ_SERIAL_NUMBER_CMD, 64'h0, 9);
        read_cmp(1'b1, sid_pkg::READ_UNIQUE_IDENTIFIER_CMD,
                 UID_VAL, 8);
        // Opcode only counts as the first byte of a frame
        sid_host_i.frame(1'b0, 8'h00, 3,
                         {104'h0, sid_pkg::READ_SERIAL_NUMBER_CMD,
                          16'h0}, rx, oe);
        check({7'h0, oe}, 8'h00);
        // Write without a preceding enable frame is refused
        sid_host_i.frame(1'b0, sid_pkg::WRITE_SERIAL_NUMBER_CMD, 8,
                         rnd128(), rx, oe);
        read_cmp(1'b0, sid_pkg::READ_SERIAL_NUMBER_CMD, 64'h0, 8);

        // Random serials plus an all-ones corner, both SPI modes
        for (int n = 0; n < 4; n++)
        begin
            sn[63:8] = (n == 3) ? 56'hFF_FFFF_FFFF_FFFF
                                : 56'({$urandom, $urandom});
            sn[7:0]  = crc8(sn[63:8]);
            sid_host_i.frame(n[0], sid_pkg::WRITE_ENABLE_LATCH_SET_CMD,
                             0, 128'h0, rx, oe);
            // Ninth byte must not overwrite byte 0
            sid_host_i.frame(n[0], sid_pkg::WRITE_SERIAL_NUMBER_CMD, 9,
                             {56'h0, ~sn[7:0], sn}, rx, oe);
            // Latch was used up by the previous write
            sid_host_i.frame(n[1], sid_pkg::WRITE_SERIAL_NUMBER_CMD, 8,
                             {64'h0, ~sn}, rx, oe);
            read_cmp(n[1], sid_pkg::READ_SERIAL_NUMBER_CMD, sn, 11);
        end

        // Deep sleep entry, wake pulse, wake window
        sid_host_i.frame(1'b0, sid_pkg::DEEP_SLEEP_CMD, 0, 128'h0, rx, oe);
        wait_flag(1'b0, cnt);
        check({7'h0, entry_ok(cnt, sid_pkg::DEEP_SLEEP_ENTRY_CYC)},
              8'h01);
        check({7'h0, spi_so_oe}, 8'h00);
        sid_host_i.frame(1'b1, sid_pkg::READ_SERIAL_NUMBER_CMD, 2,
                         rnd128(), rx, oe);
        check({7'h0, oe}, 8'h00);
        repeat (10) @(posedge core_clk);
        check({7'h0, deep_sleep_active}, 8'h00);
        sid_host_i.frame(1'b0, sid_pkg::READ_SERIAL_NUMBER_CMD, 2,
                         rnd128(), rx, oe);
        check({7'h0, oe}, 8'h00);
        repeat (2600) @(posedge core_clk);
        read_cmp(1'b0, sid_pkg::READ_SERIAL_NUMBER_CMD, sn, 8);

        // Hibernate entry and wake by a dummy opcode-only access
        sid_host_i.frame(1'b0, sid_pkg::HIBERNATE_CMD, 0, 128'h0, rx, oe);
        wait_flag(1'b1, cnt);
        check({7'h0, entry_ok(cnt, sid_pkg::HIBERNATE_ENTRY_CYC)},
              8'h01);
        sid_host_i.frame(1'b0, sid_pkg::READ_SERIAL_NUMBER_CMD, 0,
                         128'h0, rx, oe);
        check({7'h0, oe}, 8'h00);
        check({7'h0, hibernate_active}, 8'h00);
        repeat (60) @(posedge core_clk);
        read_cmp(1'b1, sid_pkg::READ_UNIQUE_IDENTIFIER_CMD,
                 UID_VAL, 9);
        end_sim();
    end
endmodule // testbench
